/* File: refm_event_flags.sv */
// event flag and mask registers with active-low interrupt request
//
// Behaviour
// - power key rising edge sets flag bit 7
// - supply overvoltage sets flag bit 5
// - supply undervoltage sets flag bit 4
// - output faults set flag bits 1 to 3
// - mask bit one blocks matching event interrupt
// - reset clears flags and masks; bit 6 unused
// - mask bit 5 gates overvoltage interrupt
// - mask bit 4 gates undervoltage interrupt
// - mask bits 1 to 3 gate output faults
// - overtemp sets bit 0; mask bit 0 gates
// - mask bit 7 gates power key edge
`timescale 1ns/1ps
`default_nettype none
module refm_event_flags
   import refm_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // raw event sources
   input  wire logic                       power_key,
   input  wire refm_pkg::refm_events_type  events_in,
   // register access from the serial engine
   input  wire refm_pkg::refm_reg_req_type reg_req,
   output logic [7:0]                      reg_rdata,
   output logic                            reg_hit,
   // interrupt request
   output logic                            interrupt_request_n
);
   import refm_pkg::*;

   // ********************************
   // state
   // ********************************
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] masks;
      logic [7:0] rdata;
      logic       hit;
      logic       irq_n;
   } refm_state_type;

   refm_state_type state_r;
   refm_state_type state_nxt;
   logic           key_rise;
   logic [7:0]     set_vec;
   logic [7:0]     clr_vec;

   function automatic logic [7:0] refm_read(input logic [7:0] addr,
                                            input logic [7:0] flags,
                                            input logic [7:0] masks);
      logic [7:0] v;
      v = 8'h00;
      if (addr == REFM_FLAGS_ADDR) begin
         v = flags & REFM_USED_BITS;
      end else if (addr == REFM_MASKS_ADDR) begin
         v = masks & REFM_USED_BITS;
      end
      return v;
   endfunction

   refm_edge_detect u_key_edge (
      .clk        (clk),
      .rst_n      (rst_n),
      .level_in   (power_key),
      .rise_pulse (key_rise)
   );

   // ********************************
   // event to bit mapping
   // ********************************
   always_comb begin
      set_vec = 8'h00;
      set_vec[REFM_BIT_KEY] = key_rise;
      set_vec[REFM_BIT_OVERV] = events_in.supply_overvoltage;
      set_vec[REFM_BIT_UNDERV] = events_in.supply_undervoltage;
      set_vec[REFM_BIT_OUT1] = events_in.out_regulation_fault[0];
      set_vec[REFM_BIT_OUT2] = events_in.out_regulation_fault[1];
      set_vec[REFM_BIT_OUT3] = events_in.out_regulation_fault[2];
      set_vec[REFM_BIT_OVERTEMP] = events_in.overtemp;
   end

   // ********************************
   // next state
   // ********************************
   always_comb begin
      state_nxt = state_r;
      clr_vec   = 8'h00;
      // host write of 1 clears a flag
      if (reg_req.wr_en && reg_req.addr == REFM_FLAGS_ADDR) begin
         clr_vec = reg_req.wdata;
      end
      // set wins over a same-cycle clear
      state_nxt.flags = ((state_r.flags & ~clr_vec) | set_vec) & REFM_USED_BITS;
      if (reg_req.wr_en && reg_req.addr == REFM_MASKS_ADDR) begin
         state_nxt.masks = reg_req.wdata & REFM_USED_BITS;
      end
      state_nxt.hit = reg_req.rd_en &&
                      (reg_req.addr == REFM_FLAGS_ADDR || reg_req.addr == REFM_MASKS_ADDR);
      state_nxt.rdata = reg_req.rd_en ? refm_read(reg_req.addr, state_r.flags, state_r.masks)
                                      : state_r.rdata;
      state_nxt.irq_n = ~|(state_nxt.flags & ~state_nxt.masks);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r.flags <= REFM_FLAGS_RESET;
         state_r.masks <= REFM_MASKS_RESET;
         state_r.rdata <= 8'h00;
         state_r.hit   <= 1'b0;
         state_r.irq_n <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata           = state_r.rdata;
   assign reg_hit             = state_r.hit;
   assign interrupt_request_n = state_r.irq_n;
endmodule
`default_nettype wire

/* File: refm_pkg.sv */
// package: register map, bit positions and carrier types of the regulator event block
`default_nettype none
package refm_pkg;

   // ********************************
   // register map
   // ********************************
   localparam logic [7:0] REFM_FLAGS_ADDR  = 8'h10;
   localparam logic [7:0] REFM_MASKS_ADDR  = 8'h11;
   localparam logic [7:0] REFM_FLAGS_RESET = 8'h00;
   localparam logic [7:0] REFM_MASKS_RESET = 8'h00;
   // bit 6 is unused in both registers
   localparam logic [7:0] REFM_USED_BITS   = 8'hbf;

   // ********************************
   // bit positions
   // ********************************
   localparam int REFM_BIT_OVERTEMP = 0;
   localparam int REFM_BIT_OUT1     = 1;
   localparam int REFM_BIT_OUT2     = 2;
   localparam int REFM_BIT_OUT3     = 3;
   localparam int REFM_BIT_UNDERV   = 4;
   localparam int REFM_BIT_OVERV    = 5;
   localparam int REFM_BIT_KEY      = 7;

   // ********************************
   // carrier types
   // ********************************
   typedef struct packed {
      logic       power_key;
      logic       supply_overvoltage;
      logic       supply_undervoltage;
      logic [2:0] out_regulation_fault;
      logic       overtemp;
   } refm_events_type;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } refm_reg_req_type;

endpackage
`default_nettype wire

/* File: refm_edge_detect.sv */
// rising edge detector for the power key input
`timescale 1ns/1ps
`default_nettype none
module refm_edge_detect (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // level in, pulse out
   input  wire logic level_in,
   output logic      rise_pulse
);
   typedef struct packed {
      logic prev;
   } refm_edge_state_type;

   refm_edge_state_type state_r;
   refm_edge_state_type state_nxt;

   always_comb begin
      state_nxt      = state_r;
      state_nxt.prev = level_in;
   end

   // prev resets high so a key held through reset gives no false edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r.prev <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rise_pulse = level_in & ~state_r.prev;
endmodule
`default_nettype wire

/* File: refm_properties.sv */
// checker: register and interrupt timing of the event flag block
`timescale 1ns/1ps
`default_nettype none
module refm_properties
   import refm_pkg::*;
(
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic                       power_key,
   input wire refm_pkg::refm_events_type  events_in,
   input wire refm_pkg::refm_reg_req_type reg_req,
   input wire logic [7:0]                 reg_rdata,
   input wire logic                       reg_hit,
   input wire logic                       interrupt_request_n
);
   logic [7:0] m_r;
   // mask mirror, so the request checks know which events may fire
   always_ff @(posedge clk)
      if (!rst_n) m_r <= 8'h00;
      else if (reg_req.wr_en && reg_req.addr == REFM_MASKS_ADDR) m_r <= reg_req.wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_hit: assert property (reg_req.rd_en && reg_req.addr[7:1] == 7'h08 |=> reg_hit)
      else $error("no hit");
   a_read_miss: assert property (reg_req.rd_en && reg_req.addr > 8'h11 |=> !reg_hit)
      else $error("bad hit");
   a_spare_bit: assert property (reg_hit |-> !reg_rdata[6])
      else $error("bit 6 set");
   a_ot_irq: assert property (events_in.overtemp && !m_r[0] |=> !interrupt_request_n)
      else $error("overtemp irq");
   a_out_irq: assert property ((events_in.out_regulation_fault & ~m_r[3:1]) != 3'h0
      |=> !interrupt_request_n) else $error("fault irq");
   a_ov_irq: assert property (events_in.supply_overvoltage && !m_r[5] |=> !interrupt_request_n)
      else $error("ov irq");
   a_uv_irq: assert property (events_in.supply_undervoltage && !m_r[4] |=> !interrupt_request_n)
      else $error("uv irq");
   a_key_irq: assert property ($rose(power_key) && $past(rst_n) && !m_r[7]
      |=> !interrupt_request_n) else $error("key irq");
   a_all_masked: assert property (&m_r[5:0] && m_r[7] |=> interrupt_request_n)
      else $error("masked irq");
endmodule
`default_nettype wire

/* File: refm_host_model.sv */
// host model: issues single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module refm_host_model
   import refm_pkg::*;
(
   input  wire logic                      clk,
   output var refm_pkg::refm_reg_req_type reg_req
);
   initial reg_req = '0;
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req = {w, !w, a, d};
      @(posedge clk);
      #1 reg_req = '0;
   endtask
endmodule
`default_nettype wire

/* File: regulator_event_flags_and_masks_tb.sv */
// testbench: event flags, masks and request line
`timescale 1ns/1ps
`default_nettype none
module regulator_event_flags_and_masks_tb;
   import refm_pkg::*;
   logic             clk, rst_n, power_key, reg_hit, interrupt_request_n;
   logic [7:0]       reg_rdata;
   refm_events_type  events_in;
   refm_reg_req_type reg_req;
   int               bad_count, n_compared;
   refm_event_flags refm_event_flags_i (.clk, .rst_n, .power_key, .events_in, .reg_req,
      .reg_rdata, .reg_hit, .interrupt_request_n);
   refm_host_model refm_host_model_i (.clk, .reg_req);
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      refm_host_model_i.acc(1'b0, a, 8'h00);
      chk(reg_rdata, e);
      chk({7'h00, reg_hit}, {7'h00, (a == REFM_FLAGS_ADDR) || (a == REFM_MASKS_ADDR)});
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      rst_n = 0;
      power_key = 0;
      events_in = '0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      chk({7'h00, interrupt_request_n}, 8'h01);
      rd(REFM_FLAGS_ADDR, 8'h00);
      rd(REFM_MASKS_ADDR, 8'h00);
      rd(8'h12, 8'h00);
      // each source, first unmasked, then masked: the flag sets either way
      for (int i = 0; i < 8; i++) if (i != 6) begin
         for (int m = 0; m < 2; m++) begin
            refm_host_model_i.acc(1'b1, REFM_MASKS_ADDR, 8'(m << i));
            @(posedge clk);
            #1 if (i == 7) power_key = 1; else events_in = 7'(1 << i);
            @(posedge clk);
            #1 events_in = '0;
            power_key = 0;
            chk({7'h00, interrupt_request_n}, 8'(m));
            rd(REFM_FLAGS_ADDR, 8'(1 << i));
            refm_host_model_i.acc(1'b1, REFM_FLAGS_ADDR, 8'(1 << i));
            @(posedge clk);
            #1 chk({7'h00, interrupt_request_n}, 8'h01);
         end
      end
      // an event in the same cycle as its clear keeps the flag set
      events_in.overtemp = 1'b1;
      refm_host_model_i.acc(1'b1, REFM_FLAGS_ADDR, 8'h01);
      events_in = '0;
      rd(REFM_FLAGS_ADDR, 8'h01);
      refm_host_model_i.acc(1'b1, REFM_FLAGS_ADDR, 8'h01);
      rd(REFM_FLAGS_ADDR, 8'h00);
      refm_host_model_i.acc(1'b1, REFM_MASKS_ADDR, 8'hff);
      rd(REFM_MASKS_ADDR, 8'hbf);
      report_and_stop;
   end
endmodule
bind refm_event_flags refm_properties refm_properties_i (.clk, .rst_n, .power_key,
   .events_in, .reg_req, .reg_rdata, .reg_hit, .interrupt_request_n);
`default_nettype wire
